// ### src/flp_lock_top.sv
// Purpose: Lock and protection logic for on-chip program flash
// Assumes: Fuse and extra-array storage live here as registers; flash array is outside
// Notes: Requests are checked in one cycle; refused ones never reach the array
// Function
// - Three hardware lock bits decode into four levels.
// - Level 2 and up: external table reads get no internal code bytes.
// - Level 2 and up: access pin latched at reset, later changes ignored.
// - Level 2 and up: parallel programming refused; ISP and API still allowed.
// - Level 3 and up: parallel verify reads refused.
// - Level 4: external execution blocked; delivered at level 4.
// - Chip erase clears flash and returns hardware fuses to unprogrammed.
// - Part identification readable in parallel mode at any level.
// - Delivered fuses: loader jump programmed, speed and RAM unprogrammed, level 4.
// - ISP code access gated only by software lock bits.
// - Defaults: boot vector FCh, boot status FFh, security byte FFh.
// - Software registers reachable by parallel, ISP and application calls.
// - Software bits 11 no protection; 01 refuses ISP programming.
// - Software high bit 0 also refuses ISP verify reads.
// - Access pin high fetches internal; low fetches external.
`timescale 1ns/1ps
`include "flp_consts.svh"
module flp_lock_top
  import flp_pkg::*;
#(
  parameter logic [31:0] PART_ID = 32'h1234_5678  // Arbitrary identity value
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins
  input wire logic external_access_pin_in,
  // Access requests
  input wire flp_req_t req_in,
  input wire logic [1:0] id_sel_in,
  output flp_rsp_t rsp_out,
  // Flash array controls
  output logic array_prog_out,
  output logic array_erase_out,
  // Fetch control and fuse view
  output flp_fetch_t fetch_out,
  output flp_hw_level_t hw_level_out,
  output logic [7:0] hardware_fuse_byte_out,
  output logic [7:0] soft_boot_vector_out,
  output logic [7:0] boot_status_byte_out,
  output logic [7:0] soft_security_byte_out
);
  // ==========================================
  // Storage
  logic [7:0] hw_fuse_q, hw_fuse_d;
  logic [7:0] boot_vec_q, boot_vec_d;
  logic [7:0] boot_stat_q, boot_stat_d;
  logic [7:0] sec_byte_q, sec_byte_d;
  logic pin_lat_q, pin_lat_d;
  logic boot_q, boot_d;
  flp_hw_level_t lvl_q, lvl_d;
  flp_rsp_t rsp_q, rsp_d;
  logic prog_q, prog_d;
  logic erase_q, erase_d;
  logic pin_sync;
  logic [2:0] hw_lock_field;
  logic [1:0] sw_lock_field;
  flp_hw_level_t lvl_now;
  logic pin_eff;

  flp_sync2 i_flp_sync2 (
    .clk_sys_in(clk_sys_in),
    .d_in(external_access_pin_in),
    .q_out(pin_sync)
  );

  assign hw_lock_field = hw_fuse_q[`FLP_HW_LOCK_LSB +: 3];
  assign sw_lock_field = sec_byte_q[1:0];

  // ==========================================
  // Lock decode
  always_comb begin
    if (!hw_lock_field[2]) begin
      lvl_now = FLP_HW_LVL4;
    end else if (!hw_lock_field[1]) begin
      lvl_now = FLP_HW_LVL3;
    end else if (!hw_lock_field[0]) begin
      lvl_now = FLP_HW_LVL2;
    end else begin
      lvl_now = FLP_HW_LVL1;
    end
  end

  // Level held from reset release so mid-run fuse writes wait for next reset
  always_comb begin
    boot_d = 1'b0;
    lvl_d = boot_q ? lvl_now : lvl_q;
    pin_lat_d = boot_q ? pin_sync : pin_lat_q;
  end

  // Pin tracked live below level 2, frozen at reset otherwise
  assign pin_eff = (lvl_q == FLP_HW_LVL1) ? pin_sync : pin_lat_q;

  // Level 4 blocks external execution; it does not redirect the fetch
  always_comb begin
    fetch_out.fetch_internal = pin_eff;
    fetch_out.table_read_blocked = (lvl_q != FLP_HW_LVL1);
    fetch_out.ext_exec_blocked = (lvl_q == FLP_HW_LVL4);
  end

  // ==========================================
  // Access checks
  always_comb begin
    logic ok;
    logic [7:0] rd;
    ok = 1'b0;
    rd = 8'h00;
    hw_fuse_d = hw_fuse_q;
    boot_vec_d = boot_vec_q;
    boot_stat_d = boot_stat_q;
    sec_byte_d = sec_byte_q;
    prog_d = 1'b0;
    erase_d = 1'b0;
    // Storage is not reset, so requests during reset must not touch it
    if (req_in.valid && !rst_in) begin
      unique case (req_in.op)
        FLP_OP_READ_CODE: begin
          if (req_in.src == FLP_SRC_PAR) begin
            ok = (lvl_q == FLP_HW_LVL1) || (lvl_q == FLP_HW_LVL2);
          end else if (req_in.src == FLP_SRC_ISP) begin
            ok = sw_lock_field[1];
          end else begin
            ok = 1'b1;
          end
        end
        FLP_OP_PROG_CODE: begin
          if (req_in.src == FLP_SRC_PAR) begin
            ok = (lvl_q == FLP_HW_LVL1);
          end else if (req_in.src == FLP_SRC_ISP) begin
            ok = (sw_lock_field == 2'b11);
          end else begin
            ok = 1'b1;
          end
          prog_d = ok;
        end
        FLP_OP_CHIP_ERASE: begin
          ok = 1'b1;
          erase_d = 1'b1;
          hw_fuse_d = `FLP_HW_FUSE_ERASED;
          boot_vec_d = `FLP_BOOT_VEC_RESET;
          boot_stat_d = `FLP_BOOT_STAT_RESET;
          sec_byte_d = `FLP_SEC_RESET;
        end
        FLP_OP_READ_EXTRA: begin
          ok = 1'b1;
          unique case (req_in.extra_addr)
            `FLP_EXTRA_ADDR_BOOT_VEC: rd = boot_vec_q;
            `FLP_EXTRA_ADDR_BOOT_STAT: rd = boot_stat_q;
            `FLP_EXTRA_ADDR_SEC: rd = sec_byte_q;
            `FLP_EXTRA_ADDR_ID: rd = PART_ID[8*id_sel_in +: 8];
          endcase
        end
        FLP_OP_WRITE_EXTRA: begin
          ok = (req_in.extra_addr != `FLP_EXTRA_ADDR_ID);
          if (ok) begin
            unique case (req_in.extra_addr)
              `FLP_EXTRA_ADDR_BOOT_VEC: boot_vec_d = req_in.wdata;
              `FLP_EXTRA_ADDR_BOOT_STAT: boot_stat_d = req_in.wdata;
              `FLP_EXTRA_ADDR_SEC: begin
                // Bits only move toward programmed; upper bits kept at one
                sec_byte_d = `FLP_SEC_KEEP_MASK | (sec_byte_q & req_in.wdata);
              end
              default: ;
            endcase
          end
        end
        FLP_OP_WRITE_HW: begin
          ok = (req_in.src == FLP_SRC_PAR);
          // Fuses only get programmed; erase is the sole way back
          if (ok) begin
            hw_fuse_d = hw_fuse_q & req_in.wdata;
          end
        end
        FLP_OP_READ_HW: begin
          ok = (req_in.src == FLP_SRC_PAR);
          rd = hw_fuse_q;
        end
        default: ok = 1'b0;
      endcase
    end
    rsp_d.grant = req_in.valid && ok;
    rsp_d.refuse = req_in.valid && !ok;
    rsp_d.rdata = ok ? rd : 8'h00;
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      boot_q <= 1'b1;
      lvl_q <= FLP_HW_LVL4;
      pin_lat_q <= 1'b1;
      rsp_q <= '0;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      lvl_q <= lvl_d;
      pin_lat_q <= pin_lat_d;
      rsp_q <= rsp_d;
      prog_q <= prog_d;
      erase_q <= erase_d;
    end
  end

  // Nonvolatile contents: loaded once at power-up, kept through rst_in
  logic nv_init_q = 1'b0;
  always_ff @(posedge clk_sys_in) begin
    nv_init_q <= 1'b1;
    if (!nv_init_q) begin
      hw_fuse_q <= `FLP_HW_FUSE_DELIVERED;
      boot_vec_q <= `FLP_BOOT_VEC_RESET;
      boot_stat_q <= `FLP_BOOT_STAT_RESET;
      sec_byte_q <= `FLP_SEC_RESET;
    end else begin
      hw_fuse_q <= hw_fuse_d;
      boot_vec_q <= boot_vec_d;
      boot_stat_q <= boot_stat_d;
      sec_byte_q <= sec_byte_d;
    end
  end

  assign rsp_out = rsp_q;
  assign array_prog_out = prog_q;
  assign array_erase_out = erase_q;
  assign hw_level_out = lvl_q;
  assign hardware_fuse_byte_out = hw_fuse_q;
  assign soft_boot_vector_out = boot_vec_q;
  assign boot_status_byte_out = boot_stat_q;
  assign soft_security_byte_out = sec_byte_q;
endmodule : flp_lock_top

// ### include/flp_consts.svh
// Purpose: Offsets, field positions, reset values for flash lock protection
// Assumes: Included by bare name
// Notes: Active-low fuse convention, 0 means programmed
`ifndef FLP_CONSTS_SVH
`define FLP_CONSTS_SVH
// ==========================================
// Hardware fuse byte layout
`define FLP_HW_DOUBLE_SPEED_BIT 7
`define FLP_HW_LOADER_JUMP_BIT 6
`define FLP_HW_AUX_RAM_BIT 3
`define FLP_HW_LOCK_LSB 0
`define FLP_HW_FUSE_DELIVERED 8'hb8
`define FLP_HW_FUSE_ERASED 8'hff
// ==========================================
// Extra array registers
`define FLP_EXTRA_ADDR_BOOT_VEC 2'h0
`define FLP_EXTRA_ADDR_BOOT_STAT 2'h1
`define FLP_EXTRA_ADDR_SEC 2'h2
`define FLP_EXTRA_ADDR_ID 2'h3
`define FLP_BOOT_VEC_RESET 8'hfc
`define FLP_BOOT_STAT_RESET 8'hff
`define FLP_SEC_RESET 8'hff
`define FLP_SEC_KEEP_MASK 8'hfc
`endif

// ### include/flp_pkg.sv
// Purpose: Types for flash lock protection
// Assumes: None
// Notes: Levels numbered as in the lock tables
package flp_pkg;
  typedef enum logic [1:0] {
    FLP_HW_LVL1,
    FLP_HW_LVL2,
    FLP_HW_LVL3,
    FLP_HW_LVL4
  } flp_hw_level_t;
  typedef enum logic [1:0] {
    FLP_SRC_PAR,
    FLP_SRC_ISP,
    FLP_SRC_API
  } flp_src_t;
  typedef enum logic [2:0] {
    FLP_OP_READ_CODE,
    FLP_OP_PROG_CODE,
    FLP_OP_CHIP_ERASE,
    FLP_OP_READ_EXTRA,
    FLP_OP_WRITE_EXTRA,
    FLP_OP_WRITE_HW,
    FLP_OP_READ_HW
  } flp_op_t;
  typedef struct packed {
    logic valid;
    flp_src_t src;
    flp_op_t op;
    logic [1:0] extra_addr;
    logic [7:0] wdata;
  } flp_req_t;
  typedef struct packed {
    logic grant;
    logic refuse;
    logic [7:0] rdata;
  } flp_rsp_t;
  typedef struct packed {
    logic fetch_internal;
    logic table_read_blocked;
    logic ext_exec_blocked;
  } flp_fetch_t;
endpackage : flp_pkg

// ### src/flp_sync2.sv
// Purpose: Two-flop synchroniser for a pin level
// Assumes: Single clock domain after the second flop
// Notes: First stage read only by the second
`timescale 1ns/1ps
module flp_sync2 (
  // Clock
  input wire logic clk_sys_in,
  // Data
  input wire logic d_in,
  output logic q_out
);
  logic s1_q;
  logic s2_q;
  // No reset: the real pin level must stand here when reset ends
  always_ff @(posedge clk_sys_in) begin
    s1_q <= d_in;
    s2_q <= s1_q;
  end
  assign q_out = s2_q;
endmodule : flp_sync2

// ### tb/flp_lock_props.sv
// Purpose: Port checks for flash lock protection
// Assumes: Answer one cycle after the taking edge
// Notes: Fuse writes act on the level only after a reset
`timescale 1ns/1ps
module flp_lock_props
  import flp_pkg::*;
#(
  parameter logic [31:0] PART_ID = 32'h0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Watched ports
  input wire flp_req_t req_in,
  input wire logic [1:0] id_sel_in,
  input wire flp_rsp_t rsp_out,
  input wire logic array_prog_out,
  input wire logic array_erase_out,
  input wire flp_fetch_t fetch_out,
  input wire flp_hw_level_t hw_level_out,
  input wire logic [7:0] hardware_fuse_byte_out,
  input wire logic [7:0] soft_security_byte_out
);
  // ==========================================
  // Request decode
  wire logic pv = req_in.valid && req_in.src == FLP_SRC_PAR;
  wire logic iv = req_in.valid && req_in.src == FLP_SRC_ISP;
  wire logic [1:0] sl = soft_security_byte_out[1:0];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  AST_PAR_PROG: assert property (
    pv && req_in.op == FLP_OP_PROG_CODE && hw_level_out != FLP_HW_LVL1
    |=> rsp_out.refuse && !array_prog_out) else $error("par program not refused");
  AST_PAR_READ: assert property (
    pv && req_in.op == FLP_OP_READ_CODE && hw_level_out inside {FLP_HW_LVL3, FLP_HW_LVL4}
    |=> rsp_out.refuse && rsp_out.rdata == 8'h00) else $error("par verify not refused");
  AST_PART_ID: assert property (
    pv && req_in.op == FLP_OP_READ_EXTRA && req_in.extra_addr == 2'h3
    |=> rsp_out.grant && rsp_out.rdata == PART_ID[8*$past(id_sel_in) +: 8])
    else $error("part id read wrong");
  AST_ERASE: assert property (
    pv && req_in.op == FLP_OP_CHIP_ERASE
    |=> rsp_out.grant && array_erase_out && hardware_fuse_byte_out == 8'hff)
    else $error("chip erase wrong");
  AST_ISP_PROG: assert property (
    iv && req_in.op == FLP_OP_PROG_CODE && sl != 2'b11
    |=> rsp_out.refuse && !array_prog_out) else $error("isp program not refused");
  AST_ISP_READ: assert property (
    iv && req_in.op == FLP_OP_READ_CODE && !sl[1] |=> rsp_out.refuse)
    else $error("isp verify not refused");
  AST_EXT_EXEC: assert property (
    fetch_out.ext_exec_blocked == (hw_level_out == FLP_HW_LVL4))
    else $error("external execution block wrong");
  AST_TABLE_READ: assert property (
    fetch_out.table_read_blocked == (hw_level_out != FLP_HW_LVL1))
    else $error("table read block wrong");
  AST_LEVEL_LATCH: assert property (
    $fell(rst_in) |=> hw_level_out == (!$past(hardware_fuse_byte_out[2]) ? 2'h3 :
      !$past(hardware_fuse_byte_out[1]) ? 2'h2 : {1'b0, !$past(hardware_fuse_byte_out[0])}))
    else $error("level not taken from fuses at reset");
  AST_PIN_LATCH: assert property (
    (hw_level_out != FLP_HW_LVL1 && $stable(hw_level_out)) [*2]
    |=> $stable(fetch_out.fetch_internal)) else $error("pin not latched");
endmodule : flp_lock_props
bind flp_lock_top flp_lock_props #(.PART_ID(PART_ID)) i_flp_lock_props (.*);

// ### tb/flp_prog_model.sv
// Purpose: Programmer and ISP host model issuing lock requests
// Assumes: One request at a time, answer one cycle after it is taken
// Notes: Idle address and data lines carry inverted values so stale data never matches
`timescale 1ns/1ps
`include "flp_consts.svh"
module flp_prog_model
  import flp_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Device side
  input wire flp_rsp_t rsp_in,
  output flp_req_t req_out
);
  initial req_out = '0;
  // ==========================================
  // Transfer
  task automatic xfer(input flp_src_t s, input flp_op_t o, input logic [1:0] a,
                      input logic [7:0] w, output flp_rsp_t r);
    logic [7:0] m;
    m = (o == FLP_OP_WRITE_EXTRA && a == `FLP_EXTRA_ADDR_SEC) ?
        `FLP_SEC_KEEP_MASK : 8'h00;
    @(posedge clk_sys_in);
    req_out <= '{1'b1, s, o, a, w | m};
    @(posedge clk_sys_in);
    req_out <= '{1'b0, s, o, ~a, ~(w | m)};
    #1 r = rsp_in;
  endtask : xfer
endmodule : flp_prog_model

// ### tb/test_flp_lock_top.sv
// Purpose: Self-checking bench for flash lock protection
// Assumes: Delivered fuse state at power-up
// Notes: Lock levels are raised one by one across resets
`timescale 1ns/1ps
`include "flp_consts.svh"
module test_flp_lock_top
  import flp_pkg::*;
;
  localparam logic [31:0] PID = 32'ha5c3_3c5a;  // Arbitrary identity value
  localparam flp_src_t P = FLP_SRC_PAR;
  localparam flp_src_t I = FLP_SRC_ISP;
  localparam flp_op_t RC = FLP_OP_READ_CODE;
  localparam flp_op_t PC = FLP_OP_PROG_CODE;
  localparam flp_op_t WX = FLP_OP_WRITE_EXTRA;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic pin = 1'b1;
  logic [1:0] id_sel = 2'h0;
  logic [7:0] hw_w [3] = '{8'hfe, 8'hfc, 8'hf8};
  flp_req_t req;
  flp_rsp_t rsp, r;
  flp_fetch_t fetch;
  flp_hw_level_t lvl;
  logic prog, erase;
  logic [7:0] fuse, boot_vec, boot_stat, sec_byte;
  int error_cnt = 0;
  int checked = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  flp_lock_top #(.PART_ID(PID)) i_flp_lock_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .external_access_pin_in(pin), .req_in(req), .id_sel_in(id_sel), .rsp_out(rsp),
    .array_prog_out(prog), .array_erase_out(erase), .fetch_out(fetch), .hw_level_out(lvl),
    .hardware_fuse_byte_out(fuse), .soft_boot_vector_out(boot_vec),
    .boot_status_byte_out(boot_stat), .soft_security_byte_out(sec_byte));
  flp_prog_model i_flp_prog_model (.clk_sys_in(clk_sys_in), .rsp_in(rsp), .req_out(req));
  // ==========================================
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input flp_src_t s, input flp_op_t o, input logic [1:0] a,
                    input logic [7:0] w, input logic g);
    i_flp_prog_model.xfer(s, o, a, w, r);
    chk("grant", {7'h0, g}, {7'h0, r.grant});
    chk("refuse", {7'h0, !g}, {7'h0, r.refuse});
  endtask : go
  task automatic reset(input int n);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask : reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    error_cnt++;
    wrap_up();
  end
  // ==========================================
  // Sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 chk("fuse", 8'h28, {2'b00, fuse[7:6], fuse[3:0]});
    chk("boot_vec", 8'hfc, boot_vec);
    chk("boot_stat", 8'hff, boot_stat);
    chk("sec_byte", 8'hff, sec_byte);
    chk("level", {6'h0, FLP_HW_LVL4}, {6'h0, lvl});
    chk("ext_exec", 8'h1, {7'h0, fetch.ext_exec_blocked});
    go(P, PC, 2'h0, 8'h5a, 1'b0);
    chk("prog", 8'h0, {7'h0, prog});
    go(P, RC, 2'h0, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in) id_sel <= 2'(i);
      go(P, FLP_OP_READ_EXTRA, `FLP_EXTRA_ADDR_ID, 8'h00, 1'b1);
      chk("id", PID[8*i +: 8], r.rdata);
    end
    go(I, PC, 2'h0, 8'h11, 1'b1);
    chk("prog", 8'h1, {7'h0, prog});
    go(FLP_SRC_API, WX, `FLP_EXTRA_ADDR_BOOT_VEC, 8'h7c, 1'b1);
    go(P, FLP_OP_READ_EXTRA, `FLP_EXTRA_ADDR_BOOT_VEC, 8'h00, 1'b1);
    chk("boot_vec", 8'h7c, r.rdata);
    go(P, FLP_OP_CHIP_ERASE, 2'h0, 8'h00, 1'b1);
    chk("erase", 8'h1, {7'h0, erase});
    chk("fuse", 8'hff, fuse);
    reset(2);
    repeat (3) @(posedge clk_sys_in);
    #1 chk("level", {6'h0, FLP_HW_LVL1}, {6'h0, lvl});
    chk("fetch_int", 8'h1, {7'h0, fetch.fetch_internal});
    @(posedge clk_sys_in) pin <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1 chk("fetch_int", 8'h0, {7'h0, fetch.fetch_internal});
    go(I, WX, `FLP_EXTRA_ADDR_BOOT_STAT, 8'h00, 1'b1);
    chk("boot_stat", 8'h00, boot_stat);
    go(I, WX, `FLP_EXTRA_ADDR_SEC, 8'h02, 1'b1);
    chk("sec_byte", 8'hfe, sec_byte);
    go(I, PC, 2'h0, 8'h22, 1'b0);
    go(I, RC, 2'h0, 8'h00, 1'b1);
    go(I, WX, `FLP_EXTRA_ADDR_SEC, 8'h00, 1'b1);
    chk("sec_byte", 8'hfc, sec_byte);
    go(I, RC, 2'h0, 8'h00, 1'b0);
    go(I, WX, `FLP_EXTRA_ADDR_ID, 8'h00, 1'b0);
    go(P, PC, 2'h0, 8'h33, 1'b1);
    foreach (hw_w[i]) begin
      go(P, FLP_OP_WRITE_HW, 2'h0, hw_w[i], 1'b1);
      // Level 3 pass latches a low pin, the others a high one
      @(posedge clk_sys_in) pin <= (i != 1);
      reset(2);
      repeat (3) @(posedge clk_sys_in);
      pin <= (i == 1);
      repeat (4) @(posedge clk_sys_in);
      #1 chk("level", {6'h0, 2'(i + 1)}, {6'h0, lvl});
      chk("fetch_int", {7'h0, i != 1}, {7'h0, fetch.fetch_internal});
      chk("ext_blk", {7'h0, i == 2}, {7'h0, fetch.ext_exec_blocked});
      chk("tbl_blk", 8'h1, {7'h0, fetch.table_read_blocked});
      go(P, RC, 2'h0, 8'h00, i == 0);
      go(P, PC, 2'h0, 8'h44, 1'b0);
    end
    wrap_up();
  end
endmodule : test_flp_lock_top
